// ==== hdl/qec_pkg.sv ====
// Constants, field layouts and carriers for the quadrature encoder counter.
// Assumes a 32-bit classic Wishbone register bus with byte addressing.
package qec_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [3:0] QEC_OFS_CONTROL = 4'h0;
	localparam logic [3:0] QEC_OFS_FILTER = 4'h4;
	localparam logic [3:0] QEC_OFS_POSITION = 4'h8;
	localparam logic [3:0] QEC_OFS_MAXIMUM = 4'hC;
	localparam logic [3:0] QEC_OFS_IRQ = 4'h0;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int QEC_CTL_ERR_BIT = 15;
	localparam int QEC_CTL_DIR_BIT = 11;
	localparam int QEC_CTL_MODE_LSB = 8;
	localparam int QEC_CTL_PRES_BIT = 2;

	// ----------------------------------------
	// Filter control register fields
	// ----------------------------------------
	localparam int QEC_FLT_COUNT_ERROR_IRQ_DISABLE_BIT = 8;
	localparam int QEC_FLT_OUTEN_BIT = 7;
	localparam int QEC_FLT_DIV_LSB = 4;
	localparam int QEC_FLT_IMV_LSB = 0;

	// ----------------------------------------
	// Interrupt flag register (offset 0x10)
	// ----------------------------------------
	localparam logic [4:0] QEC_OFS_IRQFLAG = 5'h10;
	localparam int QEC_IRQ_FLAG_BIT = 0;

	// ----------------------------------------
	// Modes and reset values
	// ----------------------------------------
	localparam logic [2:0] QEC_MODE_X2_INDEX = 3'h4;
	localparam logic [2:0] QEC_MODE_X2_MATCH = 3'h5;
	localparam logic [2:0] QEC_MODE_X4_INDEX = 3'h6;
	localparam logic [2:0] QEC_MODE_X4_MATCH = 3'h7;
	localparam logic [15:0] QEC_POS_RESET = 16'h0000;
	localparam logic [15:0] QEC_MAX_RESET = 16'hFFFF;
	localparam logic [15:0] QEC_ALL_ONES = 16'hFFFF;
	localparam logic [2:0] QEC_FILT_STABLE = 3'h3;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic phase_a;
		logic phase_b;
		logic index;
	} qec_chan_s;

	typedef struct packed {
		logic count_error_flag;
		logic [2:0] encoder_mode_field;
		logic position_reset_enable;
		logic count_error_irq_disable;
		logic filter_output_enable;
		logic [2:0] filter_clock_divide;
		logic [1:0] index_match_value;
	} qec_cfg_s;

	typedef struct packed {
		qec_cfg_s cfg;
		logic [15:0] position_count;
		logic [15:0] maximum_count;
		logic encoder_irq_flag;
		logic count_direction;
		qec_chan_s last;
		qec_chan_s filt;
		logic [5:0] [1:0] stab;
		logic [7:0] div_cnt;
		logic [31:0] rdata;
		logic ack;
	} qec_state_s;

endpackage : qec_pkg

// ==== hdl/qec_top.sv ====
// Quadrature encoder counter with noise filters and a Wishbone slave.
// Assumes encoder inputs already synchronous to clk_i; one clock domain.
`timescale 1ns/10ps

module qec_top (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Encoder pins
	input wire qec_pkg::qec_chan_s enc_i,
	// Status pins
	output logic count_direction_o,
	output logic encoder_irq_flag_o
);
	import qec_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	qec_state_s st_ff;
	qec_state_s nxt_st;

	logic filt_tick;
	logic [7:0] div_len;
	qec_chan_s eff;
	qec_chan_s raw;
	logic edge_a;
	logic edge_b;
	logic dir;
	logic count_pulse;
	logic x4_mode;
	logic index_mode;
	logic index_match;
	logic index_rise;
	logic [15:0] pos;
	logic evt;
	logic err_set;
	logic wr;
	logic [31:0] wdata;

	assign raw = enc_i;

	// ----------------------------------------
	// Combinational next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		evt = 1'b0;
		err_set = 1'b0;
		// Divide by 2^field; a free-running prescaler keeps this cheap
		div_len = 8'h01 << st_ff.cfg.filter_clock_divide;
		filt_tick = (st_ff.div_cnt >= div_len - 8'h01);
		if (filt_tick) begin
			nxt_st.div_cnt = 8'h00;
		end else begin
			nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
		end
		// Three-sample filter per channel, shared generate-free via packed arrays
		for (int i = 0; i < 3; i++) begin
			if (filt_tick) begin
				nxt_st.stab[i] = (raw[i] == st_ff.stab[i+3][0]) ?
					((st_ff.stab[i] == QEC_FILT_STABLE[1:0]) ? st_ff.stab[i] :
					st_ff.stab[i] + 2'h1) : 2'h1;
				nxt_st.stab[i+3] = {1'b0, raw[i]};
				if (raw[i] == st_ff.stab[i+3][0] &&
					st_ff.stab[i] == 2'h2) begin
					nxt_st.filt[i] = raw[i];
				end
			end
		end
		eff = st_ff.cfg.filter_output_enable ? st_ff.filt : raw;
		x4_mode = st_ff.cfg.encoder_mode_field[1];
		index_mode = (st_ff.cfg.encoder_mode_field == QEC_MODE_X2_INDEX) ||
			(st_ff.cfg.encoder_mode_field == QEC_MODE_X4_INDEX);
		edge_a = eff.phase_a ^ st_ff.last.phase_a;
		edge_b = eff.phase_b ^ st_ff.last.phase_b;
		// Forward when A leads B
		dir = st_ff.count_direction;
		if (edge_a) begin
			dir = eff.phase_a ^ eff.phase_b;
		end else if (edge_b) begin
			dir = ~(eff.phase_a ^ eff.phase_b);
		end
		count_pulse = st_ff.cfg.encoder_mode_field[2] &&
			(x4_mode ? (edge_a | edge_b) : edge_a);
		if (x4_mode) begin
			index_match = (eff.phase_b == st_ff.cfg.index_match_value[1]) &&
				(eff.phase_a == st_ff.cfg.index_match_value[0]);
		end else begin
			index_match = (st_ff.cfg.index_match_value[1] ? eff.phase_b : eff.phase_a)
				== st_ff.cfg.index_match_value[0];
		end
		index_rise = eff.index && !st_ff.last.index && index_match;
		nxt_st.last = eff;
		if (count_pulse) begin
			nxt_st.count_direction = dir;
		end
		pos = st_ff.position_count;
		if (count_pulse) begin
			if (!index_mode && dir && pos == st_ff.maximum_count) begin
				pos = QEC_POS_RESET;
				evt = 1'b1;
			end else if (!index_mode && !dir && pos == QEC_POS_RESET) begin
				pos = st_ff.maximum_count;
				evt = 1'b1;
			end else begin
				pos = dir ? pos + 16'h0001 : pos - 16'h0001;
			end
			if (index_mode && (pos == QEC_ALL_ONES ||
				pos == st_ff.maximum_count + 16'h0001)) begin
				nxt_st.cfg.count_error_flag = 1'b1;
				err_set = 1'b1;
				if (!st_ff.cfg.count_error_irq_disable) begin
					evt = 1'b1;
				end
			end
		end
		if (index_mode && index_rise) begin
			evt = 1'b1;
			if (st_ff.cfg.position_reset_enable) begin
				pos = QEC_POS_RESET;
			end
		end
		nxt_st.position_count = pos;
		// Bus slave, one wait state; writes land at the acknowledging edge
		wdata = wb_dat_i;
		wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack;
		nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
		nxt_st.rdata = 32'h0000_0000;
		unique case (wb_adr_i)
			{1'b0, QEC_OFS_CONTROL}: begin
				nxt_st.rdata[QEC_CTL_ERR_BIT] = st_ff.cfg.count_error_flag;
				nxt_st.rdata[QEC_CTL_DIR_BIT] = st_ff.count_direction;
				nxt_st.rdata[QEC_CTL_MODE_LSB +: 3] = st_ff.cfg.encoder_mode_field;
				nxt_st.rdata[QEC_CTL_PRES_BIT] = st_ff.cfg.position_reset_enable;
				if (wr && wb_sel_i[1]) begin
					// Hardware set wins over a clear in the same cycle
					nxt_st.cfg.count_error_flag = wdata[QEC_CTL_ERR_BIT] | err_set;
					nxt_st.cfg.encoder_mode_field = wdata[QEC_CTL_MODE_LSB +: 3];
				end
				if (wr && wb_sel_i[0]) begin
					nxt_st.cfg.position_reset_enable = wdata[QEC_CTL_PRES_BIT];
				end
			end
			{1'b0, QEC_OFS_FILTER}: begin
				nxt_st.rdata[QEC_FLT_COUNT_ERROR_IRQ_DISABLE_BIT] = st_ff.cfg.count_error_irq_disable;
				nxt_st.rdata[QEC_FLT_OUTEN_BIT] = st_ff.cfg.filter_output_enable;
				nxt_st.rdata[QEC_FLT_DIV_LSB +: 3] = st_ff.cfg.filter_clock_divide;
				nxt_st.rdata[QEC_FLT_IMV_LSB +: 2] = st_ff.cfg.index_match_value;
				if (wr && wb_sel_i[1]) begin
					nxt_st.cfg.count_error_irq_disable = wdata[QEC_FLT_COUNT_ERROR_IRQ_DISABLE_BIT];
				end
				if (wr && wb_sel_i[0]) begin
					nxt_st.cfg.filter_output_enable = wdata[QEC_FLT_OUTEN_BIT];
					nxt_st.cfg.filter_clock_divide = wdata[QEC_FLT_DIV_LSB +: 3];
					nxt_st.cfg.index_match_value = wdata[QEC_FLT_IMV_LSB +: 2];
				end
			end
			{1'b0, QEC_OFS_POSITION}: begin
				nxt_st.rdata[15:0] = st_ff.position_count;
				if (wr && wb_sel_i[0]) begin
					nxt_st.position_count[7:0] = wdata[7:0];
				end
				if (wr && wb_sel_i[1]) begin
					nxt_st.position_count[15:8] = wdata[15:8];
				end
			end
			{1'b0, QEC_OFS_MAXIMUM}: begin
				nxt_st.rdata[15:0] = st_ff.maximum_count;
				if (wr && wb_sel_i[0]) begin
					nxt_st.maximum_count[7:0] = wdata[7:0];
				end
				if (wr && wb_sel_i[1]) begin
					nxt_st.maximum_count[15:8] = wdata[15:8];
				end
			end
			QEC_OFS_IRQFLAG: begin
				nxt_st.rdata[QEC_IRQ_FLAG_BIT] = st_ff.encoder_irq_flag;
				if (wr && wb_sel_i[0] && !wdata[QEC_IRQ_FLAG_BIT]) begin
					nxt_st.encoder_irq_flag = 1'b0;
				end
			end
			default: begin
				nxt_st.rdata = 32'h0000_0000;
			end
		endcase
		if (evt) begin
			nxt_st.encoder_irq_flag = 1'b1;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
			st_ff.maximum_count <= QEC_MAX_RESET;
			st_ff.stab <= '0;
		end else if (ce_i) begin
			st_ff <= nxt_st;
		end
	end

	assign wb_dat_o = st_ff.rdata;
	assign wb_ack_o = st_ff.ack;
	assign count_direction_o = st_ff.count_direction;
	assign encoder_irq_flag_o = st_ff.encoder_irq_flag;

endmodule // qec_top

// ==== verif/qec_properties.sv ====
// Port-level checks for the encoder counter.
// Assumes binding to qec_top with ce_i held high.
`timescale 1ns/10ps
module qec_properties (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Status
	input wire logic count_direction_o,
	input wire logic encoder_irq_flag_o
);
	import qec_pkg::*;
	logic take;
	logic [2:0] mode_ff;
	assign take = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Shadow of the mode field, so idle-mode checks know when to apply
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_ff <= 3'h0;
		end else if (take && wb_we_i && wb_adr_i == 5'h00 && wb_sel_i[1]) begin
			mode_ff <= wb_dat_i[10:8];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_after_req: assert property (take |=> wb_ack_o)
		else $error("ack missing after request");
	chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_has_cause: assert property (wb_ack_o |-> $past(take))
		else $error("ack without request");
	chk_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > QEC_OFS_IRQFLAG
		|-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	chk_irq_sticky: assert property (
		encoder_irq_flag_o && !(take && wb_we_i && wb_adr_i == QEC_OFS_IRQFLAG)
		|=> encoder_irq_flag_o) else $error("irq flag dropped alone");
	chk_idle_quiet: assert property (
		mode_ff == 3'h0 && !encoder_irq_flag_o |=> !encoder_irq_flag_o)
		else $error("irq in idle mode");
	chk_dir_mirror: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == 5'h00
		|-> wb_dat_o[11] == $past(count_direction_o)) else $error("direction bit differs");
	cover property (take && wb_we_i);
	cover property ($rose(encoder_irq_flag_o));
	cover property ($fell(count_direction_o));
endmodule // qec_properties

bind qec_top qec_properties i_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.count_direction_o(count_direction_o), .encoder_irq_flag_o(encoder_irq_flag_o));

// ==== verif/qec_encoder_model.sv ====
// Behavioural incremental encoder on the counter's encoder pins.
// Assumes one-cycle step requests; spacing sets the shaft speed.
`timescale 1ns/10ps
module qec_encoder_model (
	// Clock, reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Motion requests
	input wire logic step_i,
	input wire logic fwd_i,
	input wire logic index_i,
	// Encoder pins
	output qec_pkg::qec_chan_s enc_o
);
	import qec_pkg::*;
	logic [1:0] pos_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_ff <= 2'h0;
		end else if (step_i) begin
			pos_ff <= fwd_i ? pos_ff + 2'h1 : pos_ff - 2'h1;
		end
	end
	assign enc_o.phase_a = pos_ff[1] ^ pos_ff[0];
	assign enc_o.phase_b = pos_ff[1];
	// Index only with both phases low, like a real disc
	assign enc_o.index = index_i && pos_ff == 2'h0;
endmodule // qec_encoder_model

// ==== verif/test_quadrature_encoder_counter.sv ====
// Self-checking bench for the encoder counter.
// Assumes qec_top, the encoder model and the bound checker.
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end
module test_quadrature_encoder_counter;
	import qec_pkg::*;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc = 1'h0, stb = 1'h0, we = 1'h0, step = 1'h0, fwd = 1'h0, idx = 1'h0;
	logic [4:0] adr = 5'h00;
	logic [31:0] wdat = 32'h0, rdat, dat;
	logic ack, dir, irq;
	qec_chan_s enc;
	int error_cnt = 0;
	int n_tests = 0;
	always #25 clk_i = ~clk_i;
	qec_encoder_model i_enc (.clk_i(clk_i), .rst_i(rst_i), .step_i(step), .fwd_i(fwd),
		.index_i(idx), .enc_o(enc));
	qec_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
		.wb_dat_o(dat), .wb_ack_o(ack), .enc_i(enc), .count_direction_o(dir),
		.encoder_irq_flag_o(irq));
	// ----------------------------------------
	// Bus and motion tasks
	// ----------------------------------------
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'h1 && t < 20);
		`CHK("ack", 1'h1, ack)
		rdat = dat;
		{cyc, stb, we} <= 3'h0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		wb(1'h0, a, 32'h0);
		`CHK($sformatf("reg %h", a), e, rdat)
	endtask
	task automatic mv(input logic f, input int n);
		repeat (n) begin
			@(posedge clk_i);
			{fwd, step} <= {f, 1'h1};
			@(posedge clk_i);
			step <= 1'h0;
			repeat (3) @(posedge clk_i);
		end
	endtask
	task automatic ix();
		@(posedge clk_i);
		idx <= 1'h1;
		repeat (2) @(posedge clk_i);
		idx <= 1'h0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic rs();
		@(posedge clk_i);
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(5'h00, 32'h0);
		rd(5'h04, 32'h0);
		rd(5'h08, 32'h0);
		rd(5'h0C, 32'hFFFF);
		rd(5'h10, 32'h0);
		wb(1'h1, 5'h14, 32'h1234);
		rd(5'h14, 32'h0);
		$display("t_reset done");
	endtask
	task automatic t_x4();
		rs();
		wb(1'h1, 5'h0C, 32'h3);
		wb(1'h1, 5'h00, 32'h700);
		mv(1'h1, 5);
		rd(5'h08, 32'h1);
		rd(5'h00, 32'hF00);
		mv(1'h0, 2);
		rd(5'h08, 32'h3);
		rd(5'h00, 32'h700);
		rs();
		wb(1'h1, 5'h00, 32'h500);
		mv(1'h1, 4);
		rd(5'h08, 32'h2);
		$display("t_x4 done");
	endtask
	task automatic t_idx();
		rs();
		wb(1'h1, 5'h00, 32'h604);
		wb(1'h1, 5'h04, 32'h3);
		mv(1'h1, 4);
		ix();
		rd(5'h08, 32'h4);
		wb(1'h1, 5'h04, 32'h0);
		ix();
		rd(5'h08, 32'h0);
		rd(5'h10, 32'h1);
		wb(1'h1, 5'h10, 32'h0);
		rd(5'h10, 32'h0);
		wb(1'h1, 5'h00, 32'h404);
		wb(1'h1, 5'h04, 32'h2);
		mv(1'h1, 4);
		ix();
		rd(5'h08, 32'h0);
		wb(1'h1, 5'h00, 32'h400);
		mv(1'h1, 4);
		ix();
		rd(5'h08, 32'h2);
		$display("t_idx done");
	endtask
	task automatic t_err();
		rs();
		wb(1'h1, 5'h00, 32'h600);
		mv(1'h0, 1);
		rd(5'h08, 32'hFFFF);
		rd(5'h00, 32'h8600);
		rd(5'h10, 32'h1);
		`CHK("irq pin", 1'h1, irq)
		`CHK("dir pin", 1'h0, dir)
		wb(1'h1, 5'h00, 32'h600);
		wb(1'h1, 5'h10, 32'h0);
		rd(5'h00, 32'h600);
		wb(1'h1, 5'h04, 32'h100);
		mv(1'h1, 1);
		mv(1'h0, 1);
		rd(5'h00, 32'h8600);
		rd(5'h10, 32'h0);
		$display("t_err done");
	endtask
	task automatic t_flt();
		rs();
		wb(1'h1, 5'h00, 32'h700);
		// Filter on, tick every 8 clocks: a 5-clock pulse must not count
		wb(1'h1, 5'h04, 32'hB0);
		mv(1'h1, 1);
		mv(1'h0, 1);
		repeat (40) @(posedge clk_i);
		rd(5'h08, 32'h0);
		mv(1'h1, 1);
		repeat (40) @(posedge clk_i);
		rd(5'h08, 32'h1);
		`CHK("dir pin", 1'h1, dir)
		$display("t_flt done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		rs();
		t_reset();
		t_x4();
		t_idx();
		t_err();
		t_flt();
		end_sim();
	end
	// Tests need well under 1000 cycles; 4000 leaves margin
	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end
endmodule // test_quadrature_encoder_counter
